// ===== logic/scrb_pkg.sv
// Constants for the serializer configuration register bank.
// Assumes one pixel-domain clock and a synchronous active-low reset.
package scrb_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_LINK_CTRL = 8'h04;
    localparam logic [7:0] ADDR_OUT_DRIVE = 8'h05;
    localparam logic [7:0] ADDR_RSVD_A    = 8'h06;
    localparam logic [7:0] ADDR_RSVD_B    = 8'h07;
    localparam logic [7:0] ADDR_FAULT     = 8'h08;
    localparam logic [7:0] ADDR_RSVD_C    = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MAP   = 8'h0D;
    localparam logic [7:0] ADDR_DEV_ID    = 8'h1E;
    localparam logic [7:0] ADDR_REV       = 8'h1F;

    // ----------------------------------------------------------------
    // Values after reset
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_LINK_CTRL = 8'h03;
    localparam logic [7:0] RST_OUT_DRIVE = 8'h70;
    localparam logic [7:0] RST_RSVD_A    = 8'h40;
    localparam logic [7:0] RST_RSVD_B    = 8'h22;
    localparam logic [7:0] RST_RSVD_C    = 8'h70;
    localparam logic [7:0] RST_IRQ_MAP   = 8'h0F;
    localparam logic [7:0] RST_FAULT     = 8'h0A;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BIT_SER_EN      = 7;
    localparam int BIT_CFG_LINK    = 6;
    localparam int BIT_PRBS        = 5;
    localparam int BIT_SLEEP       = 4;
    localparam int TYPE_LSB        = 2;
    localparam int BIT_REV_CC      = 1;
    localparam int BIT_FWD_CC      = 0;
    localparam int BIT_ADDR_METHOD = 7;
    localparam int BIT_FPLL_DIS    = 6;
    localparam int SWING_LSB       = 4;
    localparam int EMPH_LSB        = 0;
    localparam int BIT_IRQ         = 7;
    localparam int BIT_RSVD_DIS    = 4;
    localparam int SKEW_LSB        = 0;

    // ----------------------------------------------------------------
    // Field encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] TYPE_I2C    = 2'h0;
    localparam logic [1:0] SWING_400MV = 2'h3;
    localparam logic [3:0] EMPH_NONE   = 4'h0;
    localparam logic [3:0] SKEW_NONE   = 4'hF;

    // ----------------------------------------------------------------
    // Pin synchroniser: bit order autostart, direction, width, pos, neg, audio data, sck, ws
    // ----------------------------------------------------------------
    localparam int          N_ASYNC      = 10;
    localparam logic [9:0]  SYNC_RST     = 10'h050;
    localparam logic [2:0]  STRAP_SETTLE = 3'h6;

    typedef enum logic [0:0] {ST_WAIT, ST_DONE} scrb_strap_t;

endpackage : scrb_pkg

// ===== logic/scrb_top.sv
// Configuration register bank and input mapping of a video serializer.
// Assumes a register port fed by the control channel decoder, same clock.
// Contract
// - Autostart strap sets serial link enable inverted
// - Config link enable resets to zero
// - Pseudo-random test enable resets to zero
// - Sleep default from direction and autostart straps
// - Interface type resets 00, meaning I2C
// - Reverse control channel enable resets to one
// - Forward control channel enable resets to one
// - Addressing bit zero means register address carried
// - Filter PLL disable resets to one
// - Swing field resets 11, meaning 400mV
// - Emphasis resets 0000, meaning no preemphasis
// - Fault register read-only, two bits per leg
// - Remote interrupt drive resets zero, output low
// - Reserved bit on position 27 by default
// - Skew field resets 1111, no adjustment
// - Revision register read-only, upper nibble zero
// - Two input widths, three or four lanes
// - Three-lane mode ignores fourth lane, aux inputs
// - Audio pins feed I2S in both modes
// - Autostart low starts link, high stays idle
module scrb_top
    import scrb_pkg::*;
#(
    parameter logic [7:0] DEV_ID_VALUE = 8'hA5, // Arbitrary value
    parameter logic [3:0] REV_VALUE    = 4'h1   // Arbitrary value
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        autostart_pin,
    input  wire logic        control_direction_pin,
    input  wire logic        bus_width_pin,
    input  wire logic [1:0]  pos_leg_fault_in,
    input  wire logic [1:0]  neg_leg_fault_in,
    input  wire logic        audio_data_or_ctrl_zero,
    input  wire logic        audio_sck,
    input  wire logic        audio_ws,
    input  wire logic [27:0] lvds_bits_in,
    input  wire logic        aux_control_one,
    input  wire logic        aux_control_two,
    input  wire logic        reg_wr_en,
    input  wire logic        reg_rd_en,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic [7:0]       reg_rdata_r,
    output logic             reg_rd_valid_r,
    output logic             serial_link_enable_bit,
    output logic             config_link_enable_bit,
    output logic             pseudo_random_test_enable,
    output logic             sleep_mode,
    output logic [1:0]       base_mode_interface_type,
    output logic             reverse_ctrl_chan_enable,
    output logic             forward_ctrl_chan_enable,
    output logic             packet_addressing_method,
    output logic             filter_pll_disable,
    output logic [1:0]       output_swing_level,
    output logic [3:0]       emphasis_setting,
    output logic             remote_irq_drive,
    output logic             reserved_bit_disable,
    output logic [3:0]       lane_skew_adjust,
    output logic             iface_is_i2c_r,
    output logic             packet_has_reg_addr_r,
    output logic             swing_is_400mv_r,
    output logic             emphasis_active_r,
    output logic             skew_adjust_active_r,
    output logic             four_lane_mode_r,
    output logic             straps_done_r,
    output logic [28:0]      payload_r,
    output logic [2:0]       i2s_audio_r
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    // Registers that software may not change
    function automatic logic is_read_only(input logic [7:0] a);
        is_read_only = (a == ADDR_FAULT) || (a == ADDR_DEV_ID) || (a == ADDR_REV);
    endfunction : is_read_only

    // Register write hit at one offset
    function automatic logic wr_hit(input logic en, input logic [7:0] a,
                                    input logic [7:0] target);
        wr_hit = en && (a == target) && !is_read_only(a);
    endfunction : wr_hit

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [N_ASYNC-1:0] async_in;
    logic [N_ASYNC-1:0] sync1_r;
    logic [N_ASYNC-1:0] sync2_r;
    logic [N_ASYNC-1:0] sync3_r;
    logic [N_ASYNC-1:0] filt_r;

    // Pack pins in package order
    assign async_in = {audio_ws, audio_sck, audio_data_or_ctrl_zero, neg_leg_fault_in,
                       pos_leg_fault_in, bus_width_pin, control_direction_pin,
                       autostart_pin};

    // Three stages, change taken once stages two and three agree
    for (genvar g = 0; g < N_ASYNC; g++) begin : g_sync
        always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
                sync1_r[g] <= SYNC_RST[g];                   // Idle level, no false change
                sync2_r[g] <= SYNC_RST[g];
                sync3_r[g] <= SYNC_RST[g];
                filt_r[g]  <= SYNC_RST[g];
            end else begin
                sync1_r[g] <= async_in[g];
                sync2_r[g] <= sync1_r[g];
                sync3_r[g] <= sync2_r[g];
                if (sync2_r[g] == sync3_r[g]) begin
                    filt_r[g] <= sync3_r[g];
                end
            end
        end
    end

    logic       autostart_f;
    logic       direction_f;
    logic       width_f;
    logic [3:0] fault_f;

    // Filtered pin views
    assign autostart_f = filt_r[0];
    assign direction_f = filt_r[1];
    assign width_f     = filt_r[2];
    assign fault_f     = {filt_r[6:5], filt_r[4:3]};

    // ----------------------------------------------------------------
    // Strap capture after reset release
    // ----------------------------------------------------------------
    scrb_strap_t strap_r;
    logic [2:0]  settle_r;
    logic        strap_load;

    assign strap_load = (strap_r == ST_WAIT) && (settle_r == STRAP_SETTLE);

    // Wait for synchronisers to settle, then latch once
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            strap_r  <= ST_WAIT;
            settle_r <= 3'h0;
        end else begin
            unique case (strap_r)
                ST_WAIT: begin
                    settle_r <= settle_r + 3'h1;
                    if (strap_load) begin
                        strap_r <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    settle_r <= settle_r;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [7:0] link_ctrl_r;
    logic [7:0] out_drive_r;
    logic [7:0] rsvd_a_r;
    logic [7:0] rsvd_b_r;
    logic [7:0] rsvd_c_r;
    logic [7:0] irq_map_r;
    logic       wr_ok;
    logic       strap_link_en;
    logic       strap_sleep;
    logic [7:0] link_ctrl_nxt;

    // Writes accepted only once the straps are latched
    assign wr_ok       = reg_wr_en && (strap_r == ST_DONE);
    assign strap_link_en = !autostart_f;
    assign strap_sleep   = direction_f && autostart_f;
    assign link_ctrl_nxt = {strap_link_en, link_ctrl_r[6:5], strap_sleep, link_ctrl_r[3:0]};

    // Link and channel control, strap-loaded once
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            link_ctrl_r <= RST_LINK_CTRL;
        end else if (strap_load) begin
            link_ctrl_r <= link_ctrl_nxt;
        end else if (wr_hit(wr_ok, reg_addr, ADDR_LINK_CTRL)) begin
            link_ctrl_r <= reg_wdata;
        end
    end

    // Remaining writable registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            out_drive_r <= RST_OUT_DRIVE;
            rsvd_a_r    <= RST_RSVD_A;
            rsvd_b_r    <= RST_RSVD_B;
            rsvd_c_r    <= RST_RSVD_C;
            irq_map_r   <= RST_IRQ_MAP;
        end else begin
            if (wr_hit(wr_ok, reg_addr, ADDR_OUT_DRIVE)) out_drive_r <= reg_wdata;
            if (wr_hit(wr_ok, reg_addr, ADDR_RSVD_A))    rsvd_a_r    <= reg_wdata;
            if (wr_hit(wr_ok, reg_addr, ADDR_RSVD_B))    rsvd_b_r    <= reg_wdata;
            if (wr_hit(wr_ok, reg_addr, ADDR_RSVD_C))    rsvd_c_r    <= reg_wdata;
            if (wr_hit(wr_ok, reg_addr, ADDR_IRQ_MAP)) begin
                irq_map_r <= {reg_wdata[7], 2'h0, reg_wdata[4:0]};
            end
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [7:0] rd_mux;

    // Read-only values come from live status or parameters, never from writes
    assign rd_mux = (reg_addr == ADDR_LINK_CTRL) ? link_ctrl_r :
                    (reg_addr == ADDR_OUT_DRIVE) ? out_drive_r :
                    (reg_addr == ADDR_RSVD_A)    ? rsvd_a_r :
                    (reg_addr == ADDR_RSVD_B)    ? rsvd_b_r :
                    (reg_addr == ADDR_FAULT)     ? {4'h0, fault_f} :
                    (reg_addr == ADDR_RSVD_C)    ? rsvd_c_r :
                    (reg_addr == ADDR_IRQ_MAP)   ? irq_map_r :
                    (reg_addr == ADDR_DEV_ID)    ? DEV_ID_VALUE :
                    (reg_addr == ADDR_REV)       ? {4'h0, REV_VALUE} :
                    8'h00;

    // One-cycle read answer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_rdata_r    <= 8'h00;
            reg_rd_valid_r <= 1'b0;
        end else begin
            reg_rd_valid_r <= reg_rd_en;
            if (reg_rd_en) reg_rdata_r <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // Field outputs
    // ----------------------------------------------------------------
    assign serial_link_enable_bit    = link_ctrl_r[BIT_SER_EN];
    assign config_link_enable_bit    = link_ctrl_r[BIT_CFG_LINK];
    assign pseudo_random_test_enable = link_ctrl_r[BIT_PRBS];
    assign sleep_mode                = link_ctrl_r[BIT_SLEEP];
    assign base_mode_interface_type  = link_ctrl_r[TYPE_LSB +: 2];
    assign reverse_ctrl_chan_enable  = link_ctrl_r[BIT_REV_CC];
    assign forward_ctrl_chan_enable  = link_ctrl_r[BIT_FWD_CC];
    assign packet_addressing_method  = out_drive_r[BIT_ADDR_METHOD];
    assign filter_pll_disable        = out_drive_r[BIT_FPLL_DIS];
    assign output_swing_level        = out_drive_r[SWING_LSB +: 2];
    assign emphasis_setting          = out_drive_r[EMPH_LSB +: 4];
    assign remote_irq_drive          = irq_map_r[BIT_IRQ];
    assign reserved_bit_disable      = irq_map_r[BIT_RSVD_DIS];
    assign lane_skew_adjust          = irq_map_r[SKEW_LSB +: 4];
    assign straps_done_r             = (strap_r == ST_DONE);

    // ----------------------------------------------------------------
    // Decoded modes and input mapping
    // ----------------------------------------------------------------
    logic        bit27_sel;
    logic [28:0] payload_nxt;

    // Reserved bit or aux control one on position 27
    assign bit27_sel   = reserved_bit_disable ? aux_control_one : lvds_bits_in[27];
    assign payload_nxt = width_f ? {aux_control_two, bit27_sel, lvds_bits_in[26:0]}
                                 : {8'h00, lvds_bits_in[20:0]};

    // Registered decodes, payload and audio
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            iface_is_i2c_r        <= 1'b1;
            packet_has_reg_addr_r <= 1'b1;
            swing_is_400mv_r      <= 1'b1;
            emphasis_active_r     <= 1'b0;
            skew_adjust_active_r  <= 1'b0;
            four_lane_mode_r      <= 1'b0;
            payload_r             <= 29'h0000_0000;
            i2s_audio_r           <= 3'h0;
        end else begin
            iface_is_i2c_r        <= (base_mode_interface_type == TYPE_I2C);
            packet_has_reg_addr_r <= !packet_addressing_method;
            swing_is_400mv_r      <= (output_swing_level == SWING_400MV);
            emphasis_active_r     <= (emphasis_setting != EMPH_NONE);
            skew_adjust_active_r  <= (lane_skew_adjust != SKEW_NONE);
            four_lane_mode_r      <= width_f;
            payload_r             <= payload_nxt;
            i2s_audio_r           <= filt_r[9:7];
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_write(logic [7:0] a);
        reg_wr_en && straps_done_r && (reg_addr == a);
    endsequence

    sequence s_read(logic [7:0] a);
        reg_rd_en && (reg_addr == a);
    endsequence

    property p_strap_link_en;
        strap_load |=> (serial_link_enable_bit == !$past(autostart_f));
    endproperty
    a_strap_link_en: assert property (p_strap_link_en)
        else $error("serial link enable not set from autostart");

    property p_reset_link;
        $rose(rst_n) |-> !config_link_enable_bit && !pseudo_random_test_enable
                         && reverse_ctrl_chan_enable && forward_ctrl_chan_enable;
    endproperty
    a_reset_link: assert property (p_reset_link)
        else $error("link control wrong after reset");

    property p_strap_sleep;
        strap_load |=> (sleep_mode == ($past(direction_f) && $past(autostart_f)));
    endproperty
    a_strap_sleep: assert property (p_strap_sleep)
        else $error("sleep default not set from straps");

    property p_reset_drive;
        $rose(rst_n) |-> filter_pll_disable && (output_swing_level == SWING_400MV)
                         && (emphasis_setting == EMPH_NONE) && !packet_addressing_method;
    endproperty
    a_reset_drive: assert property (p_reset_drive)
        else $error("output drive wrong after reset");

    property p_fault_ro;
        s_write(ADDR_FAULT) ##2 s_read(ADDR_FAULT) |=>
            (reg_rdata_r == {4'h0, $past(fault_f)});
    endproperty
    a_fault_ro: assert property (p_fault_ro)
        else $error("fault status changed by write");

    property p_irq_low;
        $rose(rst_n) |-> !remote_irq_drive && !reserved_bit_disable
                         && (lane_skew_adjust == SKEW_NONE);
    endproperty
    a_irq_low: assert property (p_irq_low)
        else $error("interrupt map wrong after reset");

    property p_bit27;
        width_f && !reserved_bit_disable |=> (payload_r[27] == $past(lvds_bits_in[27]));
    endproperty
    a_bit27: assert property (p_bit27)
        else $error("position 27 not fed by reserved bit");

    property p_rev;
        s_read(ADDR_REV) |=> (reg_rdata_r == {4'h0, REV_VALUE}) && reg_rd_valid_r;
    endproperty
    a_rev: assert property (p_rev)
        else $error("revision read wrong");

    property p_three_lane;
        !width_f |=> (payload_r[28:21] == 8'h00) && !four_lane_mode_r;
    endproperty
    a_three_lane: assert property (p_three_lane)
        else $error("three-lane mode passes fourth lane");

    property p_audio;
        ##1 (i2s_audio_r == $past(filt_r[9:7]));
    endproperty
    a_audio: assert property (p_audio)
        else $error("audio path broken");

    property p_id_ro;
        s_write(ADDR_DEV_ID) ##2 s_read(ADDR_DEV_ID) |=> (reg_rdata_r == DEV_ID_VALUE);
    endproperty
    a_id_ro: assert property (p_id_ro)
        else $error("identifier changed by write");

endmodule : scrb_top

// ===== sim/scrb_mcu_model.sv
// Microcontroller model driving the register strobe port of the bank.
// Assumes the bank samples on the rising sys_clk edge; drives 1 ns after it.
module scrb_mcu_model (
    input  wire logic       sys_clk,
    input  wire logic       reg_rd_valid_r,
    input  wire logic [7:0] reg_rdata_r,
    output logic            reg_wr_en,
    output logic            reg_rd_en,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle bus at time zero
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end

    // One write strobe; released lines flip so stale values never match
    task write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk) #1;
        reg_wr_en = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(posedge sys_clk) #1;
        reg_wr_en = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask : write_reg

    // One read strobe; waits a bounded time for the valid pulse
    task read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        int n;
        @(posedge sys_clk) #1;
        reg_rd_en = 1'b1;
        reg_addr  = a;
        @(posedge sys_clk) #1;
        reg_rd_en = 1'b0;
        reg_addr  = ~a;
        ok        = 1'b0;
        d         = 8'h00;
        for (n = 0; n < 4 && ok == 1'b0; n++) begin
            if (reg_rd_valid_r === 1'b1) begin
                ok = 1'b1;
                d  = reg_rdata_r;
            end else begin
                @(posedge sys_clk) #1;
            end
        end
    endtask : read_reg
endmodule : scrb_mcu_model

// ===== sim/testbench.sv
// Self-checking bench for the serializer configuration register bank.
// Assumes scrb_pkg, scrb_top and scrb_mcu_model are compiled first.
module testbench
    import scrb_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {logic [7:0] addr; logic [7:0] exp;} scrb_row_t;

    logic        sys_clk, rst_n, autostart_pin, control_direction_pin, bus_width_pin;
    logic [1:0]  pos_leg_fault_in, neg_leg_fault_in, output_swing_level;
    logic        audio_data_or_ctrl_zero, audio_sck, audio_ws, aux_control_one;
    logic        aux_control_two, reg_wr_en, reg_rd_en, reg_rd_valid_r, straps_done_r;
    logic [27:0] lvds_bits_in;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata_r;
    logic        serial_link_enable_bit, remote_irq_drive, reserved_bit_disable;
    logic [3:0]  emphasis_setting, lane_skew_adjust;
    logic        iface_is_i2c_r, packet_has_reg_addr_r, swing_is_400mv_r;
    logic        emphasis_active_r, skew_adjust_active_r, four_lane_mode_r;
    logic [28:0] payload_r;
    logic [2:0]  i2s_audio_r;
    int          miscompares = 0;
    int          compares    = 0;

    // Reset view with both straps low, ids arbitrary
    scrb_row_t rows [10] = '{'{ADDR_LINK_CTRL, 8'h83}, '{ADDR_OUT_DRIVE, 8'h70},
        '{ADDR_RSVD_A, 8'h40}, '{ADDR_RSVD_B, 8'h22}, '{ADDR_FAULT, 8'h0A},
        '{ADDR_RSVD_C, 8'h70}, '{ADDR_IRQ_MAP, 8'h0F}, '{ADDR_DEV_ID, 8'h5A},
        '{ADDR_REV, 8'h02}, '{8'h10, 8'h00}};

    scrb_top #(.DEV_ID_VALUE(8'h5A), .REV_VALUE(4'h2)) dut (
        .sys_clk, .rst_n, .autostart_pin, .control_direction_pin, .bus_width_pin,
        .pos_leg_fault_in, .neg_leg_fault_in, .audio_data_or_ctrl_zero, .audio_sck,
        .audio_ws, .lvds_bits_in, .aux_control_one, .aux_control_two, .reg_wr_en,
        .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata_r, .reg_rd_valid_r,
        .serial_link_enable_bit, .config_link_enable_bit(), .pseudo_random_test_enable(),
        .sleep_mode(), .base_mode_interface_type(), .reverse_ctrl_chan_enable(),
        .forward_ctrl_chan_enable(), .packet_addressing_method(), .filter_pll_disable(),
        .output_swing_level, .emphasis_setting, .remote_irq_drive, .reserved_bit_disable,
        .lane_skew_adjust, .iface_is_i2c_r, .packet_has_reg_addr_r, .swing_is_400mv_r,
        .emphasis_active_r, .skew_adjust_active_r, .four_lane_mode_r, .straps_done_r,
        .payload_r, .i2s_audio_r);

    scrb_mcu_model mcu (.sys_clk, .reg_rd_valid_r, .reg_rdata_r, .reg_wr_en, .reg_rd_en,
        .reg_addr, .reg_wdata);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task finish_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    task tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task chk(input logic [28:0] got, input logic [28:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       ok;
        mcu.read_reg(a, d, ok);
        if (ok !== 1'b1) begin
            miscompares++;
            $display("ERROR at %0t: no read answer", $time);
            finish_test();
        end
        chk({21'h0, d}, {21'h0, e}, "read data");
    endtask : rd

    task run_rows();
        foreach (rows[i]) rd(rows[i].addr, rows[i].exp);
    endtask : run_rows

    // Straps held across release; bounded wait for the strap latch
    task do_reset();
        rst_n = 1'b0;
        tick(20);
        rst_n = 1'b1;
        for (int n = 0; n < 40 && straps_done_r !== 1'b1; n++) tick(1);
        if (straps_done_r !== 1'b1) begin
            miscompares++;
            $display("ERROR at %0t: straps never latched", $time);
            finish_test();
        end
    endtask : do_reset

    // Clock generator, pixel clock inside the three-lane range
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {autostart_pin, control_direction_pin, bus_width_pin} = 3'b000;
        {pos_leg_fault_in, neg_leg_fault_in} = 4'b1010;
        {audio_data_or_ctrl_zero, audio_sck, audio_ws} = 3'b000;
        {aux_control_one, aux_control_two} = 2'b11;
        lvds_bits_in = 28'h7FF_FFFF;
        do_reset();
        run_rows();
        chk({iface_is_i2c_r, packet_has_reg_addr_r, swing_is_400mv_r, emphasis_active_r,
            skew_adjust_active_r}, 5'b11100, "decodes");
        chk(payload_r, 29'h001F_FFFF, "three lane word");
        chk({four_lane_mode_r, serial_link_enable_bit}, 2'b01, "mode");
        // Read-only places keep their contents
        mcu.write_reg(ADDR_FAULT, 8'hFF);
        rd(ADDR_FAULT, 8'h0A);
        mcu.write_reg(ADDR_DEV_ID, 8'h00);
        rd(ADDR_DEV_ID, 8'h5A);
        mcu.write_reg(ADDR_REV, 8'hFF);
        run_rows();
        pos_leg_fault_in = 2'b11;
        tick(8);
        rd(ADDR_FAULT, 8'h0B);
        // Drive field write, then decodes a cycle later
        mcu.write_reg(ADDR_OUT_DRIVE, 8'h83);
        chk({output_swing_level, emphasis_setting}, 6'h03, "drive fields");
        tick(1);
        chk({packet_has_reg_addr_r, swing_is_400mv_r, emphasis_active_r}, 3'b001,
            "drive decodes");
        mcu.write_reg(ADDR_IRQ_MAP, 8'hFF);
        chk({remote_irq_drive, reserved_bit_disable, lane_skew_adjust}, 6'h3F, "irq");
        rd(ADDR_IRQ_MAP, 8'h9F);
        // Four-lane word with aux bits, then reserved bit restored
        bus_width_pin = 1'b1;
        tick(8);
        chk(payload_r, 29'h1FFF_FFFF, "four lane aux");
        mcu.write_reg(ADDR_IRQ_MAP, 8'h0E);
        tick(2);
        chk(payload_r, 29'h17FF_FFFF, "four lane reserved");
        chk({28'h0, skew_adjust_active_r}, 29'h1, "skew decode");
        {audio_data_or_ctrl_zero, audio_sck, audio_ws} = 3'b100;
        tick(8);
        chk({26'h0, i2s_audio_r}, 29'h1, "audio");
        // Non-I2C interface type decodes a cycle after the field
        mcu.write_reg(ADDR_LINK_CTRL, 8'h8B);
        tick(1);
        chk({28'h0, iface_is_i2c_r}, 29'h0, "iface decode");
        // Second power-up with both straps high
        {autostart_pin, control_direction_pin} = 2'b11;
        do_reset();
        rd(ADDR_LINK_CTRL, 8'h13);
        chk({28'h0, serial_link_enable_bit}, 29'h0, "link idle");
        finish_test();
    end

    // Hang guard
    initial begin
        #200000;
        miscompares++;
        $display("ERROR at %0t: run limit reached", $time);
        finish_test();
    end
endmodule : testbench
